/* inc/mic_pkg.sv */
// What this block does
// - eighteen interrupt sources, each assignable to low or high priority.
// - a valid source event sets that source's pending flag to one.
// - flags set even when disabled; disabled flags raise no request.
// - enabled pending flag raises request; long call to fixed vector at instruction end.
// - return from handler resumes the interrupted program flow.
// - each source has an enable; requests only while it is set.
// - individual enables count only while the global enable is one.
// - global enable at zero suppresses every source's request.
// - request sampled before an enable clear may still be taken.
// - enable clear followed by multi-cycle instruction blocks the posted request.
// - some flags clear themselves when the call to their vector starts.
// - flag still set after return re-enters after one more instruction.
// - software setting a flag acts exactly like a hardware event.
// - high preempts a low handler; high handlers never preempted; low default.
// - simultaneous requests: higher level first, then fixed source order.
// - sampled every clock; fastest response six cycles, one detect five call.
// - requests of equal or lower level wait for the running handler's return.
package mic_pkg;
    localparam int          NUM_SRC       = 18;
    localparam int          IDX_W         = 5;
    localparam int          VEC_W         = 16;
    localparam logic [15:0] VEC_BASE      = 16'h0003;
    localparam int          VEC_SHIFT     = 3;
    localparam logic [2:0]  CALL_CYCLES   = 3'h5;
    localparam logic [17:0] AUTO_CLR_MASK = 18'h0000F;
    localparam logic [17:0] PEND_RST      = 18'h00000;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_call = 2'b01
    } mic_state_e;

    typedef struct packed {
        logic [17:0] pending;
        logic        req_valid;
        logic        req_high;
        logic [4:0]  req_idx;
        mic_state_e  state;
        logic [2:0]  cnt;
        logic        act_hi;
        logic        act_lo;
        logic [15:0] vec_addr;
        logic [4:0]  vec_src;
    } mic_state_s;
endpackage : mic_pkg

/* inc/mic_arb_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface mic_arb_if;
    logic [17:0] req_hi;
    logic [17:0] req_lo;
    logic        grant_valid;
    logic        grant_high;
    logic [4:0]  grant_idx;

    modport ctrl (output req_hi, output req_lo,
                  input grant_valid, input grant_high, input grant_idx);
    modport arb  (input req_hi, input req_lo,
                  output grant_valid, output grant_high, output grant_idx);
endinterface : mic_arb_if
`default_nettype wire

/* logic/mic_arbiter.sv */
`timescale 1ns/100ps
`default_nettype none
module mic_arbiter (
    mic_arb_if.arb bus
);
    // lowest set index wins
    function automatic logic [4:0] mic_first_set(input logic [17:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = mic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : mic_first_set

    always_comb begin
        bus.grant_valid = 1'b0;
        bus.grant_high  = 1'b0;
        bus.grant_idx   = 5'h00;
        if (|bus.req_hi) begin
            bus.grant_valid = 1'b1;
            bus.grant_high  = 1'b1;
            bus.grant_idx   = mic_first_set(bus.req_hi);
        end else if (|bus.req_lo) begin
            bus.grant_valid = 1'b1;
            bus.grant_idx   = mic_first_set(bus.req_lo);
        end
    end
endmodule : mic_arbiter
`default_nettype wire

/* logic/mic_top.sv */
`timescale 1ns/100ps
`default_nettype none
module mic_top (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_ce,
    input  wire logic [17:0] i_src_event,
    input  wire logic [17:0] i_sw_set,
    input  wire logic [17:0] i_sw_clr,
    input  wire logic [17:0] i_src_enable,
    input  wire logic [17:0] i_src_high_prio,
    input  wire logic        i_global_irq_enable,
    input  wire logic        i_instr_done,
    input  wire logic        i_return_from_handler,
    output logic      [17:0] o_pending,
    output logic             o_irq_request,
    output logic             o_long_call_to_vector,
    output logic      [15:0] o_vector_addr,
    output logic      [4:0]  o_vector_src,
    output logic             o_in_service_hi,
    output logic             o_in_service_lo
);
    mic_pkg::mic_state_s s_reg;
    mic_pkg::mic_state_s s_next;
    logic                start_call;
    logic [17:0]         live;
    logic                gie_lo;
    logic                gie_hi;
    logic [17:0]         grant_1h;

    mic_arb_if arb_bus ();

    mic_arbiter u_arb (
        .bus (arb_bus.arb)
    );

    // requests: enable, global enable and in-service level gate the flags
    assign live   = s_reg.pending & i_src_enable;
    assign gie_hi = i_global_irq_enable & ~s_reg.act_hi;
    assign gie_lo = i_global_irq_enable & ~s_reg.act_hi & ~s_reg.act_lo;
    assign arb_bus.req_hi = live & i_src_high_prio & {18{gie_hi}};
    assign arb_bus.req_lo = live & ~i_src_high_prio & {18{gie_lo}};

    // call starts only at a normal instruction end, never at the return itself
    assign start_call = i_ce && (s_reg.state == mic_pkg::st_idle) && i_instr_done
                        && !i_return_from_handler && s_reg.req_valid;

    assign grant_1h = 18'h00001 << s_reg.req_idx;

    always_comb begin
        s_next = s_reg;
        // set wins over any clear
        s_next.pending = (s_reg.pending & ~i_sw_clr) | i_src_event | i_sw_set;
        if (start_call) begin
            s_next.pending = (s_reg.pending & ~i_sw_clr & ~(grant_1h & mic_pkg::AUTO_CLR_MASK))
                             | i_src_event | i_sw_set;
        end
        // one detect cycle: the sampled request holds the previous cycle's decision
        s_next.req_valid = arb_bus.grant_valid;
        s_next.req_high  = arb_bus.grant_high;
        s_next.req_idx   = arb_bus.grant_idx;
        if (i_return_from_handler) begin
            if (s_reg.act_hi) begin
                s_next.act_hi = 1'b0;
            end else begin
                s_next.act_lo = 1'b0;
            end
        end
        case (s_reg.state)
            mic_pkg::st_idle: begin
                if (start_call) begin
                    s_next.state    = mic_pkg::st_call;
                    s_next.cnt      = mic_pkg::CALL_CYCLES - 3'h1;
                    s_next.vec_src  = s_reg.req_idx;
                    s_next.vec_addr = mic_pkg::VEC_BASE
                                      + (16'(s_reg.req_idx) << mic_pkg::VEC_SHIFT);
                    if (s_reg.req_high) begin
                        s_next.act_hi = 1'b1;
                    end else begin
                        s_next.act_lo = 1'b1;
                    end
                end
            end
            mic_pkg::st_call: begin
                if (s_reg.cnt == 3'h0) begin
                    s_next.state = mic_pkg::st_idle;
                end else begin
                    s_next.cnt = s_reg.cnt - 3'h1;
                end
            end
            default: begin
                s_next.state = mic_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_reg <= '{pending: mic_pkg::PEND_RST, state: mic_pkg::st_idle, default: '0};
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end

    assign o_pending             = s_reg.pending;
    assign o_irq_request         = s_reg.req_valid;
    assign o_long_call_to_vector = (s_reg.state == mic_pkg::st_call);
    assign o_vector_addr         = s_reg.vec_addr;
    assign o_vector_src          = s_reg.vec_src;
    assign o_in_service_hi       = s_reg.act_hi;
    assign o_in_service_lo       = s_reg.act_lo;

    // checks
    sequence call_run_s;
        o_long_call_to_vector [*5] ##1 !o_long_call_to_vector;
    endsequence

    sequence call_begin_s;
        start_call ##1 o_long_call_to_vector;
    endsequence

    flag_set_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && |i_src_event) |=> ((o_pending & $past(i_src_event)) == $past(i_src_event)))
        else $error("hardware event did not set its flag");

    sw_set_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && |i_sw_set) |=> ((o_pending & $past(i_sw_set)) == $past(i_sw_set)))
        else $error("software set did not set its flag");

    flag_sticky_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && !start_call)
        |=> (((o_pending | $past(i_sw_clr)) & $past(o_pending)) == $past(o_pending)))
        else $error("pending flag dropped without a clear");

    global_off_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && !i_global_irq_enable) |=> !o_irq_request)
        else $error("request raised with global enable low");

    enable_gate_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && !(|(o_pending & i_src_enable))) |=> !o_irq_request)
        else $error("request raised with no enabled flag");

    call_length_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst || !i_ce)
        start_call |=> call_run_s)
        else $error("long call did not last five cycles");

    call_vector_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst || !i_ce)
        call_begin_s |-> (o_vector_addr == mic_pkg::VEC_BASE
                          + (16'($past(s_reg.req_idx)) << mic_pkg::VEC_SHIFT))
                         && (o_vector_src == $past(s_reg.req_idx)))
        else $error("wrong vector for the call");

    hi_no_preempt_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        start_call |-> !s_reg.act_hi)
        else $error("high priority handler preempted");

    lo_wait_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (start_call && !s_reg.req_high) |-> !s_reg.act_lo)
        else $error("low request taken inside a low handler");

    auto_clear_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (start_call && |(grant_1h & mic_pkg::AUTO_CLR_MASK & ~i_src_event & ~i_sw_set))
        |=> !(|(o_pending & $past(grant_1h))))
        else $error("auto clearing flag still set after vectoring");

    prio_order_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && |arb_bus.req_hi) |=> (o_irq_request && s_reg.req_high))
        else $error("high level request not chosen first");

    no_take_on_return_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_return_from_handler && !o_long_call_to_vector) |=> !o_long_call_to_vector)
        else $error("call taken at the return instruction itself");

    disabled_flag_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && |(i_src_event & ~i_src_enable))
        |=> ((o_pending & $past(i_src_event) & ~$past(i_src_enable))
             == ($past(i_src_event) & ~$past(i_src_enable))))
        else $error("disabled source event did not set its flag");

    ret_clear_hi_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_return_from_handler && o_in_service_hi) |=> !o_in_service_hi)
        else $error("return left the high handler active");

    ret_clear_lo_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_return_from_handler && !o_in_service_hi && o_in_service_lo)
        |=> !o_in_service_lo)
        else $error("return left the low handler active");

    in_service_set_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst || !i_ce)
        call_begin_s |-> ($past(s_reg.req_high) ? o_in_service_hi : o_in_service_lo))
        else $error("call did not mark its level in service");

    vector_hold_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && !start_call) |=> ($stable(o_vector_addr) && $stable(o_vector_src)))
        else $error("vector changed without a call");

    boundary_only_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && !i_instr_done && !o_long_call_to_vector) |=> !o_long_call_to_vector)
        else $error("call started without an instruction boundary");

    gie_sampled_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (start_call && $past(i_ce)) |-> $past(i_global_irq_enable))
        else $error("call taken on a request sampled with global enable low");

    grant_lowest_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        arb_bus.grant_valid
        |-> (((arb_bus.grant_high ? arb_bus.req_hi : arb_bus.req_lo)
              & ((18'h00001 << arb_bus.grant_idx) - 18'h00001)) == 18'h00000))
        else $error("a lower source of the same level was passed over");

    grant_real_a: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        arb_bus.grant_valid
        |-> |((arb_bus.grant_high ? arb_bus.req_hi : arb_bus.req_lo)
              & (18'h00001 << arb_bus.grant_idx)))
        else $error("grant given to a source that does not request");
endmodule : mic_top
`default_nettype wire

/* bench/mic_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mic_cpu_model #(
    parameter logic [3:0] GAP = 4'h2
) (
    input  wire logic i_clk,
    input  wire logic i_run,
    input  wire logic i_ret,
    input  wire logic i_call,
    output var logic  o_instr_done = 1'b0,
    output var logic  o_return_from_handler = 1'b0
);
    logic [3:0] cnt_reg = 4'h0;
    // boundaries pause during a call; a return is never a boundary too
    always @(posedge i_clk) begin
        o_instr_done          <= 1'b0;
        o_return_from_handler <= i_ret;
        if (i_call || !i_run || i_ret) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg >= GAP) begin
            o_instr_done <= 1'b1;
            cnt_reg      <= 4'h0;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule : mic_cpu_model
`default_nettype wire

/* bench/mcu_interrupt_controller_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define MIC_CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mcu_interrupt_controller_bench;
    logic        clk = 1'b0, rst = 1'b1, run = 1'b0, ret = 1'b0, gie = 1'b1;
    logic [17:0] ev = 18'h00000, ss = 18'h00000, sc = 18'h00000;
    logic [17:0] en = 18'h00000, hp = 18'h00000, pend;
    logic [15:0] vaddr;
    logic [4:0]  vsrc;
    logic        irq, call, ins_hi, ins_lo, done, rfh;
    int          checked = 0, n_fail = 0;

    always #2 clk = ~clk;

    mic_top dut (
        .i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_src_event(ev), .i_sw_set(ss),
        .i_sw_clr(sc), .i_src_enable(en), .i_src_high_prio(hp),
        .i_global_irq_enable(gie), .i_instr_done(done), .i_return_from_handler(rfh),
        .o_pending(pend), .o_irq_request(irq), .o_long_call_to_vector(call),
        .o_vector_addr(vaddr), .o_vector_src(vsrc), .o_in_service_hi(ins_hi),
        .o_in_service_lo(ins_lo)
    );
    mic_cpu_model cpu (
        .i_clk(clk), .i_run(run), .i_ret(ret), .i_call(call),
        .o_instr_done(done), .o_return_from_handler(rfh)
    );

    task hit(input logic [17:0] e, input logic [17:0] s, input logic [17:0] c);
        @(negedge clk);
        {ev, ss, sc} = {e, s, c};
        @(negedge clk);
        {ev, ss, sc} = 54'h0;
    endtask : hit

    // return from the handler, then let the in-service state settle
    task leave;
        @(negedge clk);
        ret = 1'b1;
        @(negedge clk);
        ret = 1'b0;
        repeat (2) @(negedge clk);
    endtask : leave

    task done_with(input logic [17:0] c);
        hit(18'h00000, 18'h00000, c);
        leave();
    endtask : done_with

    // wait for the call to source k; check vector, call length and level
    task take(input logic [4:0] k, input logic hi);
        int n;
        n = 0;
        while (call !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        `MIC_CHK(vsrc, k)
        `MIC_CHK(vaddr, (16'h0003 + {8'h00, k, 3'h0}))
        n = 0;
        while (call === 1'b1 && n < 9) begin
            @(negedge clk);
            n++;
        end
        `MIC_CHK(n, 5)
        `MIC_CHK((hi ? ins_hi : ins_lo), 1'b1)
    endtask : take

    task t_mask;
        {run, gie, en} = {1'b1, 1'b0, 18'h00020};
        hit(18'h00020, 18'h00000, 18'h00000);
        repeat (20) @(negedge clk);
        `MIC_CHK(pend, 18'h00020)
        `MIC_CHK({irq, ins_lo}, 2'h0)
        {gie, en} = {1'b1, 18'h00000};
        repeat (4) @(negedge clk);
        `MIC_CHK({irq, ins_lo}, 2'h0)
        {run, en} = {1'b0, 18'h00020};
        repeat (2) @(negedge clk);
        `MIC_CHK(irq, 1'b1)
        // global enable cleared under a standing request, long instruction next
        {run, gie} = {1'b1, 1'b0};
        repeat (8) @(negedge clk);
        `MIC_CHK({irq, ins_lo, pend}, 20'h00020)
        // cleared in the boundary cycle itself: the sampled request is still taken
        {run, gie} = {1'b0, 1'b1};
        repeat (2) @(negedge clk);
        run = 1'b1;
        repeat (3) @(negedge clk);
        gie = 1'b0;
        take(5'h05, 1'b0);
        gie = 1'b1;
        `MIC_CHK(pend, 18'h00020)
        done_with(18'h00020);
        `MIC_CHK({ins_lo, pend}, 19'h00000)
    endtask : t_mask

    task t_auto;
        en = 18'h00044;
        hit(18'h00000, 18'h00044, 18'h00000);
        take(5'h02, 1'b0);
        `MIC_CHK(pend, 18'h00040)
        leave();
        take(5'h06, 1'b0);
        leave();
        take(5'h06, 1'b0);
        done_with(18'h00040);
    endtask : t_auto

    task t_prio;
        {run, en, hp} = {1'b0, 18'h00E88, 18'h00400};
        hit(18'h00280, 18'h00000, 18'h00000);
        run = 1'b1;
        take(5'h07, 1'b0);
        hit(18'h00000, 18'h00000, 18'h00080);
        repeat (12) @(negedge clk);
        `MIC_CHK(vsrc, 5'h07)
        hit(18'h00000, 18'h00400, 18'h00000);
        take(5'h0A, 1'b1);
        hp = 18'h00600;
        repeat (12) @(negedge clk);
        `MIC_CHK(vsrc, 5'h0A)
        done_with(18'h00400);
        take(5'h09, 1'b1);
        done_with(18'h00200);
        leave();
        `MIC_CHK({ins_hi, ins_lo}, 2'h0)
        {run, hp} = {1'b0, 18'h00800};
        hit(18'h00808, 18'h00000, 18'h00000);
        run = 1'b1;
        take(5'h0B, 1'b1);
        done_with(18'h00800);
        take(5'h03, 1'b0);
        leave();
        `MIC_CHK(pend, 18'h00000)
    endtask : t_prio

    task final_report;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_mask();
        t_auto();
        t_prio();
        final_report();
    end

    initial begin
        repeat (4000) @(negedge clk);
        n_fail++;
        final_report();
    end
endmodule : mcu_interrupt_controller_bench
`default_nettype wire
